// File: verilog/dpws_pkg.sv
// dpws_pkg: shared constants for the display power well sequencer
// assumes a 50 MHz sys_clk and an AXI4-Lite register port with 32-bit data
package dpws_pkg;
    // ------------------------------------------------------------
    // wells, in power-up order
    // ------------------------------------------------------------
    localparam int NUM_WELLS = 5;
    localparam int WELL_BASE = 0;
    localparam int WELL_PRIMARY = 1;
    localparam int WELL_EXTERNAL = 2;
    localparam int WELL_THIRD = 3;
    localparam int WELL_FOURTH = 4;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_REQUEST = 8'h00;
    localparam logic [7:0] OFF_STATE = 8'h04;
    localparam logic [7:0] OFF_FUSE = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_ACCESS = 8'h14;
    localparam logic [7:0] OFF_DOMAIN = 8'h18;
    // ------------------------------------------------------------
    // status bit positions: [4:0] timeout per well, [9:5] well usable
    // ------------------------------------------------------------
    localparam int IRQ_TMO_LSB = 0;
    localparam int IRQ_DONE_LSB = 5;
    localparam int IRQ_W = 10;
    localparam logic [4:0] REQ_RST = 5'h00;
    localparam logic [9:0] MASK_RST = 10'h000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int TIMEOUT_US = 20;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
    localparam int ACK_DLY_CYC = 8;
    localparam int FUSE_DLY_CYC = 8;
    localparam int CNT_W = 11;
    typedef enum logic [2:0] {
        DPWS_OFF = 3'b000,
        DPWS_RISE = 3'b001,
        DPWS_FUSE = 3'b010,
        DPWS_ON = 3'b011,
        DPWS_FALL = 3'b100,
        DPWS_ERR = 3'b101
    } dpws_state_e;
endpackage

// File: verilog/dpws_well_if.sv
// dpws_well_if: command and status between the sequencer top and one well
// assumes the top drives want and allow, the well answers with its flags
`timescale 1ns/1ns
interface dpws_well_if;
    logic want;
    logic allow;
    logic on;
    logic fuse_done;
    logic usable;
    logic tmo;
    logic done_evt;
    modport ctl (output want, output allow, input on, input fuse_done, input usable,
                 input tmo, input done_evt);
    modport well (input want, input allow, output on, output fuse_done, output usable,
                  output tmo, output done_evt);
endinterface

// File: verilog/dpws_well.sv
// dpws_well: one power well, its power switch, fuse distribution and watchdog
// assumes want and allow from the top already respect the chain order
`timescale 1ns/1ns
module dpws_well
    import dpws_pkg::*;
#(
    parameter int TMO_CYC = TIMEOUT_CYC,
    parameter int ACK_CYC = ACK_DLY_CYC,
    parameter int FUSE_CYC = FUSE_DLY_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    dpws_well_if.well w
);
    import dpws_pkg::*;

    dpws_state_e state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] wdog_ff, nxt_wdog;
    logic tmo_ff, nxt_tmo;
    logic done_ff, nxt_done;

    // ------------------------------------------------------------
    // sequencing of power switch, fuse distribution and watchdog
    // ------------------------------------------------------------
    // the watchdog is kept apart from the settle counter so that a slow switch
    // shows up as an error rather than stalling the whole chain silently
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_wdog = wdog_ff + 1'b1;
        nxt_tmo = 1'b0;
        nxt_done = 1'b0;
        unique case (state_ff)
            DPWS_OFF: begin
                nxt_wdog = '0;
                if (w.want && w.allow) begin
                    nxt_state = DPWS_RISE;
                    nxt_cnt = '0;
                end
            end
            DPWS_RISE: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == CNT_W'(ACK_CYC - 1)) begin
                    nxt_state = DPWS_FUSE;
                    nxt_cnt = '0;
                    nxt_wdog = '0;
                end
            end
            DPWS_FUSE: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == CNT_W'(FUSE_CYC - 1)) begin
                    nxt_state = DPWS_ON;
                    nxt_done = 1'b1;
                end
            end
            DPWS_ON: begin
                nxt_wdog = '0;
                if (!w.want) begin
                    nxt_state = DPWS_FALL;
                    nxt_cnt = '0;
                end
            end
            DPWS_FALL: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == CNT_W'(ACK_CYC - 1)) begin
                    nxt_state = DPWS_OFF;
                end
            end
            DPWS_ERR: begin
                nxt_wdog = '0;
                // dropping the request is the only way out of an error
                if (!w.want) begin
                    nxt_state = DPWS_OFF;
                end
            end
            default: begin
                nxt_state = DPWS_OFF;
            end
        endcase
        if ((state_ff == DPWS_RISE || state_ff == DPWS_FUSE || state_ff == DPWS_FALL) &&
            wdog_ff == CNT_W'(TMO_CYC - 1) && nxt_state == state_ff) begin
            nxt_state = DPWS_ERR;
            nxt_tmo = 1'b1;
        end
    end

    // registers of the well
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= DPWS_OFF;
            cnt_ff <= '0;
            wdog_ff <= '0;
            tmo_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            wdog_ff <= nxt_wdog;
            tmo_ff <= nxt_tmo;
            done_ff <= nxt_done;
        end
    end

    // state flags seen by software
    assign w.on = (state_ff == DPWS_FUSE) || (state_ff == DPWS_ON);
    assign w.fuse_done = (state_ff == DPWS_ON);
    assign w.usable = (state_ff == DPWS_ON);
    assign w.tmo = tmo_ff;
    assign w.done_evt = done_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence rise_seq;
        state_ff == DPWS_OFF && w.want && w.allow;
    endsequence
    sequence up_seq;
        ##[1:40] state_ff == DPWS_ON;
    endsequence
    rise_to_on_a: assert property (@(posedge sys_clk) disable iff (srst)
        rise_seq |-> up_seq) else $error("well did not come up in time");
    // fuse after enable
    // fuse done may only rise after the well has reported enabled for the fuse time
    fuse_after_on_a: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(w.fuse_done) |-> $past(w.on, FUSE_CYC))
        else $error("fuse done without enabled state");
    order_block_a: assert property (@(posedge sys_clk) disable iff (srst)
        state_ff == DPWS_OFF && !w.allow |=> state_ff == DPWS_OFF)
        else $error("well left off without lower wells on");
    fall_done_a: assert property (@(posedge sys_clk) disable iff (srst)
        state_ff == DPWS_ON && !w.want |-> ##[1:20] state_ff == DPWS_OFF)
        else $error("well did not turn off in time");
    tmo_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(state_ff == DPWS_ERR) |-> w.tmo) else $error("error without timeout flag");
endmodule

// File: verilog/dpws_top.sv
// dpws_top: display power well sequencer with an AXI4-Lite register port
// assumes a single 50 MHz clock, synchronous reset, one master on the bus
//
// Behaviour
// - wells come up one by one in chain order and none may be skipped
// - the base well turns itself on whenever software touches the display engine
// - setting the external well request makes it report enabled, within 20 us
// - after enabled, the fuse distribution done flag follows within 20 us
// - wells go down in reverse order and none drops while a higher one is on
// - clearing a request makes the well report disabled within 20 us
// - the remote console function brings the external well up without software; here it still waits for a software request of the primary well
// - buffer registers stay in the base well while its logic is in the primary well
// - interrupt logic is in the base well, pipe interrupts in their pipe well
// - central power logic is in the base well, frame compression in the primary well
// - the primary well holds pipe A for DSI; VGA and pipe B are in the external well
// - the third well holds pipe C and the fourth pipe D with compression and joining
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module dpws_top
    import dpws_pkg::*;
#(
    parameter int TMO_CYC = TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic remote_console_function,
    input wire logic vga_enable_req,
    output logic vga_output_en,
    output logic [NUM_WELLS-1:0] well_power_on,
    output logic irq
);
    import dpws_pkg::*;

    // ------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------
    logic aw_ff, nxt_aw;
    logic w_ff, nxt_w;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic base_on_ff, nxt_base_on;
    logic [4:0] req_ff, nxt_req;
    logic [IRQ_W-1:0] stat_ff, nxt_stat;
    logic [IRQ_W-1:0] mask_ff, nxt_mask;
    logic vga_ff, nxt_vga;
    logic wr_go;
    logic [IRQ_W-1:0] evt;
    logic [NUM_WELLS-1:0] on_v, fuse_v, usable_v, tmo_v, done_v;

    dpws_well_if wl [NUM_WELLS] ();

    // ------------------------------------------------------------
    // well chain
    // ------------------------------------------------------------
    // want is gated by the wells above so a lower well cannot fall first
    for (genvar i = 0; i < NUM_WELLS; i++) begin : g_well
        logic req_eff;
        logic hold_up;
        if (i == WELL_BASE) begin : g_base
            assign req_eff = base_on_ff;
            assign wl[i].allow = 1'b1;
        end else if (i == WELL_EXTERNAL) begin : g_ext
            assign req_eff = req_ff[i] | remote_console_function;
            assign wl[i].allow = usable_v[i-1];
        end else begin : g_mid
            assign req_eff = req_ff[i];
            assign wl[i].allow = &usable_v[i-1:0];
        end
        if (i == NUM_WELLS - 1) begin : g_top
            assign hold_up = 1'b0;
        end else begin : g_low
            assign hold_up = |on_v[NUM_WELLS-1:i+1];
        end
        assign wl[i].want = req_eff | hold_up;
        assign on_v[i] = wl[i].on;
        assign fuse_v[i] = wl[i].fuse_done;
        assign usable_v[i] = wl[i].usable;
        assign tmo_v[i] = wl[i].tmo;
        assign done_v[i] = wl[i].done_evt;
        dpws_well #(
            .TMO_CYC(TMO_CYC),
            .ACK_CYC(ACK_DLY_CYC),
            .FUSE_CYC(FUSE_DLY_CYC)
        ) u_well (
            .sys_clk(sys_clk),
            .srst(srst),
            .w(wl[i])
        );
    end

    // power rails for the domains:
    // base holds buffer registers, interrupts, central power
    // primary pipe A and frame compression, external pipe B and VGA
    assign well_power_on = on_v;
    assign vga_output_en = vga_ff & usable_v[WELL_EXTERNAL];

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    assign evt = {done_v, tmo_v};
    assign irq = |(stat_ff & mask_ff);

    // ------------------------------------------------------------
    // AXI4-Lite slave and registers
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign wr_go = aw_ff && w_ff && !bvalid_ff;

    // address and data are latched separately so either may come first
    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_req = req_ff;
        nxt_mask = mask_ff;
        nxt_vga = vga_ff;
        nxt_base_on = base_on_ff;
        nxt_stat = stat_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (wr_go || (s_axi_arvalid && s_axi_arready)) begin
            nxt_base_on = 1'b1;
        end
        if (wr_go) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = 2'b00;
            unique case ({awaddr_ff[7:2], 2'b00})
                OFF_REQUEST: begin
                    if (wstrb_ff[0]) begin
                        nxt_req = {wdata_ff[4:1], 1'b0};
                    end
                end
                OFF_IRQ_STATUS: begin
                    // each byte lane clears only its own bits
                    if (wstrb_ff[0]) begin
                        nxt_stat[7:0] = stat_ff[7:0] & ~wdata_ff[7:0];
                    end
                    if (wstrb_ff[1]) begin
                        nxt_stat[9:8] = stat_ff[9:8] & ~wdata_ff[9:8];
                    end
                end
                OFF_IRQ_MASK: begin
                    if (wstrb_ff[0]) begin
                        nxt_mask[7:0] = wdata_ff[7:0];
                    end
                    if (wstrb_ff[1]) begin
                        nxt_mask[9:8] = wdata_ff[9:8];
                    end
                end
                OFF_ACCESS: begin
                    if (wstrb_ff[0]) begin
                        nxt_vga = wdata_ff[0];
                    end
                end
                OFF_STATE, OFF_FUSE, OFF_DOMAIN: begin
                    nxt_bresp = 2'b00;
                end
                default: begin
                    nxt_bresp = 2'b10;
                end
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        nxt_stat = nxt_stat | evt;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = 2'b00;
            unique case ({s_axi_araddr[7:2], 2'b00})
                OFF_REQUEST: nxt_rdata = {27'h0, req_ff};
                OFF_STATE: nxt_rdata = {27'h0, on_v};
                OFF_FUSE: nxt_rdata = {27'h0, fuse_v};
                OFF_IRQ_STATUS: nxt_rdata = {22'h0, stat_ff};
                OFF_IRQ_MASK: nxt_rdata = {22'h0, mask_ff};
                OFF_ACCESS: nxt_rdata = {30'h0, vga_output_en, vga_ff};
                OFF_DOMAIN: nxt_rdata = {27'h0, usable_v};
                default: begin
                    nxt_rdata = 32'h0;
                    nxt_rresp = 2'b10;
                end
            endcase
        end
    end

    // register stage for the bus and control state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'b00;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= 2'b00;
            req_ff <= REQ_RST;
            mask_ff <= MASK_RST;
            stat_ff <= '0;
            vga_ff <= 1'b0;
            base_on_ff <= 1'b0;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            req_ff <= nxt_req;
            mask_ff <= nxt_mask;
            stat_ff <= nxt_stat;
            vga_ff <= nxt_vga;
            base_on_ff <= nxt_base_on;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // chain order on power up
    chain_order_a: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(on_v[WELL_THIRD]) |-> $past(&usable_v[2:0]))
        else $error("third well rose before lower wells");
    fourth_order_a: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(on_v[WELL_FOURTH]) |-> $past(&usable_v[3:0]))
        else $error("fourth well rose before lower wells");
    reverse_down_a: assert property (@(posedge sys_clk) disable iff (srst)
        $fell(on_v[WELL_PRIMARY]) |-> !on_v[WELL_EXTERNAL] && !on_v[WELL_THIRD])
        else $error("lower well dropped under a live higher well");
    vga_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
        vga_output_en |-> fuse_v[WELL_EXTERNAL]) else $error("vga on without external well");
    base_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
        s_axi_arvalid && s_axi_arready |-> ##[1:30] usable_v[WELL_BASE])
        else $error("base well not on after access");
    tmo_sticky_a: assert property (@(posedge sys_clk) disable iff (srst)
        |tmo_v |=> |stat_ff[4:0]) else $error("timeout not recorded");
endmodule

// File: testbench/dpws_top_tb.sv
// dpws_top_tb: register-level bench for the display power well sequencer
// assumes dpws_pkg and dpws_top compiled first; drives AXI4-Lite directly
`timescale 1ns/1ns
module dpws_top_tb;
    import dpws_pkg::*;
    logic sys_clk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, rcf, vga_en, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rsp;
    logic [4:0] pw;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    dpws_top #(.TMO_CYC(TIMEOUT_CYC)) dpws_top_inst (.sys_clk(sys_clk), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .remote_console_function(rcf), .vga_enable_req(1'b0), .vga_output_en(vga_en),
        .well_power_on(pw), .irq(irq));
    // ------------------------------------------------------------
    // clock, hang guard and closing report
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // cut a hang short well past the longest expected run
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // ------------------------------------------------------------
    // bus tasks: sample ready at the negedge before the taking edge, act after it
    // ------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh, ad, wd, bd;
        ad = 1'b0;
        wd = 1'b0;
        bd = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bd) begin
            @(negedge sys_clk);
            ah = !ad && awready;
            wh = !wd && wready;
            bh = bvalid;
            if (bh) rsp = bresp;
            @(posedge sys_clk);
            if (ah) begin awvalid <= 1'b0; ad = 1'b1; end
            if (wh) begin wvalid <= 1'b0; wd = 1'b1; end
            if (bh) begin bready <= 1'b0; bd = 1'b1; end
        end
    endtask
    task automatic axi_read(input logic [7:0] a);
        logic ah, ad, rdn;
        ad = 1'b0;
        rdn = 1'b0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rdn) begin
            @(negedge sys_clk);
            ah = !ad && arready;
            rdn = rvalid;
            if (rdn) begin rd = rdata; rsp = rresp; end
            @(posedge sys_clk);
            if (ah) begin arvalid <= 1'b0; ad = 1'b1; end
            if (rdn) rready <= 1'b0;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a);
        chk(rd, exp, "register read");
    endtask
    // poll a register as software would, with a bounded number of reads
    task automatic poll_chk(input logic [7:0] a, input logic [31:0] exp);
        for (int i = 0; i < 20; i++) begin
            axi_read(a);
            if (rd === exp) break;
        end
        chk(rd, exp, "register poll");
    endtask
    // wait for the well outputs to settle on the expected pattern
    task automatic wait_pw(input logic [4:0] exp);
        for (int i = 0; i < 400 && pw !== exp; i++) @(negedge sys_clk);
        chk(32'(pw), 32'(exp), "well_power_on");
    endtask
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, rcf} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        rd_chk(OFF_REQUEST, 32'(REQ_RST));
        rd_chk(OFF_IRQ_MASK, 32'(MASK_RST));
        wait_pw(5'h01);
        axi_read(8'h40);
        chk(32'(rsp), 32'h2, "unmapped read response");
        axi_write(8'h40, 32'h1);
        chk(32'(rsp), 32'h2, "unmapped write response");
        $display("test reset_map done");
        // third and fourth wells alone must be ignored while primary and external wells are off
        axi_write(OFF_REQUEST, 32'h18);
        repeat (3 * (ACK_DLY_CYC + FUSE_DLY_CYC)) @(posedge sys_clk);
        chk(32'(pw), 32'h01, "out of order request");
        axi_write(OFF_REQUEST, 32'h1f);
        wait_pw(5'h1f);
        rd_chk(OFF_REQUEST, 32'h1e);
        rd_chk(OFF_STATE, 32'h1f);
        // the top well is still distributing fuses when it first reports enabled
        poll_chk(OFF_FUSE, 32'h1f);
        rd_chk(OFF_DOMAIN, 32'h1f);
        $display("test power_up done");
        chk(32'(irq), 32'h0, "irq while masked");
        axi_write(OFF_IRQ_MASK, 32'h3e0);
        chk(32'(irq), 32'h1, "irq on usable event");
        axi_write(OFF_IRQ_STATUS, 32'h3ff);
        rd_chk(OFF_IRQ_STATUS, 32'h0);
        chk(32'(irq), 32'h0, "irq after clear");
        $display("test interrupt done");
        // dropping lower requests while higher wells are on changes nothing
        axi_write(OFF_REQUEST, 32'h10);
        repeat (3 * ACK_DLY_CYC) @(posedge sys_clk);
        chk(32'(pw), 32'h1f, "lower well held up");
        axi_write(OFF_REQUEST, 32'h0);
        wait_pw(5'h01);
        rd_chk(OFF_STATE, 32'h01);
        $display("test power_down done");
        axi_write(OFF_ACCESS, 32'h1);
        chk(32'(vga_en), 32'h0, "vga before external well");
        rcf <= 1'b1;
        axi_write(OFF_REQUEST, 32'h02);
        wait_pw(5'h07);
        // vga follows the external well only once its fuses are done
        poll_chk(OFF_DOMAIN, 32'h07);
        chk(32'(vga_en), 32'h1, "vga after external well");
        rd_chk(OFF_ACCESS, 32'h3);
        rcf <= 1'b0;
        axi_write(OFF_REQUEST, 32'h0);
        wait_pw(5'h01);
        chk(32'(vga_en), 32'h0, "vga after power down");
        $display("test remote_console done");
        complete_run();
    end
endmodule
